// >>> src/strap_mode_config.sv
`timescale 1ns/10ps
`include "strap_mode_config_defs.svh"
// Summary of operation
// - Straps 000 load bits 13,12,10,8 as 0000: 10M half, no autoneg.
// - Straps 001 load the control bits as 0001 (10M full, no autoneg).
// - Straps 010 load 1000, carrier sense covers transmit and receive.
// - Straps 011 load 1001 and carrier sense covers receive only.
// - Straps 100 load 1100 and advertise 0100, carrier on tx and rx.
// - Straps 101 pick repeater mode, load 1100 and 0100, carrier on rx.
// - Straps 110 wake powered down, block traffic, skip strap defaults.
// - Straps 111 set autoneg on, bit 10 clear, and advertise 1111.
// - In MII the receive clock runs at 25 MHz or 2.5 MHz by speed.
// - In MII the transmit clock runs at that rate, tx taken on its rise.
// - In RMII receive outputs launch on the reference clock rising edge.
// - In RMII transmit inputs are captured on the reference clock rise.
// - Straps are sampled and loaded when the hardware reset pin releases.
// - A soft reset keeps the register contents but clears strap power-down unless the straps still read 110.
module strap_mode_config (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic hw_reset_pin_n_in,
    input wire strap_mode_config_pkg::strap_type mode_strap_in,
    input wire logic ref_clock_input_in,
    input wire logic tx_en_in,
    input wire logic [3:0] txd_in,
    output logic rx_clk_out,
    output logic tx_clk_out,
    output logic rx_dv_out,
    output logic [3:0] rxd_out,
    output logic crs_out,
    output logic power_down_out,
    output logic repeater_out,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire strap_mode_config_pkg::addr_type awaddr_in,
    input wire logic wvalid_in,
    output logic wready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    output logic bvalid_out,
    input wire logic bready_in,
    output logic [1:0] bresp_out,
    input wire logic arvalid_in,
    output logic arready_out,
    input wire strap_mode_config_pkg::addr_type araddr_in,
    output logic rvalid_out,
    input wire logic rready_in,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out
);
    import strap_mode_config_pkg::*;

    logic hw_s1_q, hw_s2_q, hw_s3_q;
    strap_type mode_s1_q, mode_s2_q;
    logic ref_s1_q, ref_s2_q, ref_s3_q;
    logic [4:0] tx_s1_q, tx_s2_q;
    reg16_type ctrl_q, adv_q, wr_val;
    strap_type mode_q;
    logic strap_pd_q, repeater_q, srst_q;
    link_type link_q;
    logic hw_rise, pd_active, dp_clear, crs_on_tx;
    logic aw_have_q, w_have_q, aw_have_d, w_have_d;
    addr_type waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_take, w_take, do_write, ar_take, wr_ctrl, wr_adv, wr_link;
    logic addr_ok;
    logic [4:0] div_q, half;
    logic mii_clk_q, mii_rise, mii_fall, ref_rise, cap_en, launch_en;
    logic [4:0] tx_cap_q;
    logic rx_dv_q, crs_q;
    logic [3:0] rxd_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // pins cross into clk_in through two flops each
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            hw_s1_q <= 1'b0;
            hw_s2_q <= 1'b0;
            hw_s3_q <= 1'b0;
            mode_s1_q <= 3'h0;
            mode_s2_q <= 3'h0;
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            ref_s3_q <= 1'b0;
            tx_s1_q <= 5'h00;
            tx_s2_q <= 5'h00;
        end
        else
        begin
            hw_s1_q <= hw_reset_pin_n_in;
            hw_s2_q <= hw_s1_q;
            hw_s3_q <= hw_s2_q;
            mode_s1_q <= mode_strap_in;
            mode_s2_q <= mode_s1_q;
            ref_s1_q <= ref_clock_input_in;
            ref_s2_q <= ref_s1_q;
            ref_s3_q <= ref_s2_q;
            tx_s1_q <= {tx_en_in, txd_in};
            tx_s2_q <= tx_s1_q;
        end
    end

    assign hw_rise = hw_s2_q && !hw_s3_q;
    assign ref_rise = ref_s2_q && !ref_s3_q;

    function automatic reg16_type put_ctrl(reg16_type base, logic [3:0] v);
        reg16_type r;
        r = base;
        r[`CTRL_SPEED_BIT] = v[3];
        r[`CTRL_ANEG_BIT] = v[2];
        r[`CTRL_ISO_BIT] = v[1];
        r[`CTRL_DUPLEX_BIT] = v[0];
        return r;
    endfunction : put_ctrl

    always_comb
    begin
        wr_val = 16'h0000;
        if (waddr_q == `CTRL_ADDR)
        begin
            wr_val = ctrl_q;
        end
        else
        begin
            wr_val = adv_q;
        end
        if (wstrb_q[0])
        begin
            wr_val[7:0] = wdata_q[7:0];
        end
        if (wstrb_q[1])
        begin
            wr_val[15:8] = wdata_q[15:8];
        end
    end

    assign wr_ctrl = do_write && waddr_q == `CTRL_ADDR;
    assign wr_adv = do_write && waddr_q == `ADV_ADDR;
    assign wr_link = do_write && waddr_q == `LINK_ADDR;

    // configuration registers and strap load
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ctrl_q <= `CTRL_RESET;
            adv_q <= `ADV_RESET;
            mode_q <= 3'h0;
            strap_pd_q <= 1'b0;
            repeater_q <= 1'b0;
            srst_q <= 1'b0;
        end
        else if (!hw_s2_q)
        begin
            ctrl_q <= `CTRL_RESET;
            adv_q <= `ADV_RESET;
            strap_pd_q <= 1'b0;
            repeater_q <= 1'b0;
            srst_q <= 1'b0;
        end
        else if (hw_rise)
        begin
            mode_q <= mode_s2_q;
            srst_q <= 1'b0;
            unique case (mode_s2_q)
                `MODE_10HD: ctrl_q <= put_ctrl(ctrl_q, `CTRL4_10HD);
                `MODE_10FD: ctrl_q <= put_ctrl(ctrl_q, `CTRL4_10FD);
                `MODE_100HD: ctrl_q <= put_ctrl(ctrl_q, `CTRL4_100HD);
                `MODE_100FD: ctrl_q <= put_ctrl(ctrl_q, `CTRL4_100FD);
                `MODE_100HD_AN:
                begin
                    ctrl_q <= put_ctrl(ctrl_q, `CTRL4_AN_100HD);
                    adv_q[`ADV_ABIL_MSB:`ADV_ABIL_LSB] <= `ADV4_100HD;
                end
                `MODE_REPEATER:
                begin
                    ctrl_q <= put_ctrl(ctrl_q, `CTRL4_AN_100HD);
                    adv_q[`ADV_ABIL_MSB:`ADV_ABIL_LSB] <= `ADV4_100HD;
                    repeater_q <= 1'b1;
                end
                `MODE_PDOWN: strap_pd_q <= 1'b1;
                `MODE_ALL:
                begin
                    ctrl_q[`CTRL_ANEG_BIT] <= 1'b1;
                    ctrl_q[`CTRL_ISO_BIT] <= 1'b0;
                    adv_q[`ADV_ABIL_MSB:`ADV_ABIL_LSB] <= `ADV4_ALL;
                end
            endcase
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= wr_val & ~(16'h0001 << `CTRL_SRST_BIT);
            srst_q <= wr_val[`CTRL_SRST_BIT];
            if (wr_val[`CTRL_SRST_BIT] && mode_s2_q != `MODE_PDOWN)
            begin
                strap_pd_q <= 1'b0;
            end
        end
        else
        begin
            srst_q <= 1'b0;
            if (wr_adv)
            begin
                adv_q <= wr_val;
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            link_q <= LINK_MII;
        end
        else if (wr_link)
        begin
            link_q <= link_type'(wdata_q[0]);
        end
    end

    // strapped power-down overrides bit 11 writes
    assign pd_active = ctrl_q[`CTRL_PDOWN_BIT] || strap_pd_q;
    assign dp_clear = !hw_s2_q || srst_q || pd_active;
    // full duplex and repeater drop tx carrier
    assign crs_on_tx = !ctrl_q[`CTRL_DUPLEX_BIT] && !repeater_q;

    assign half = ctrl_q[`CTRL_SPEED_BIT] ? `MII_HALF_100_CYC : `MII_HALF_10_CYC;
    assign mii_rise = div_q == half - 5'd1 && !mii_clk_q;
    assign mii_fall = div_q == half - 5'd1 && mii_clk_q;

    // one divider feeds both mii clocks
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            div_q <= 5'h00;
            mii_clk_q <= 1'b0;
        end
        else if (dp_clear || link_q == LINK_RMII)
        begin
            div_q <= 5'h00;
            mii_clk_q <= 1'b0;
        end
        else if (div_q >= half - 5'd1)
        begin
            div_q <= 5'h00;
            mii_clk_q <= ~mii_clk_q;
        end
        else
        begin
            div_q <= div_q + 5'd1;
        end
    end

    // capture on reference rise in rmii
    assign cap_en = link_q == LINK_RMII ? ref_rise : mii_rise;
    // launch on reference rise in rmii
    assign launch_en = link_q == LINK_RMII ? ref_rise : mii_fall;

    // near-end echo stands in for the analog receive path
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tx_cap_q <= 5'h00;
            rx_dv_q <= 1'b0;
            rxd_q <= 4'h0;
            crs_q <= 1'b0;
        end
        else if (dp_clear)
        begin
            tx_cap_q <= 5'h00;
            rx_dv_q <= 1'b0;
            rxd_q <= 4'h0;
            crs_q <= 1'b0;
        end
        else
        begin
            if (cap_en)
            begin
                tx_cap_q <= link_q == LINK_RMII ?
                    {tx_s2_q[4], 2'b00, tx_s2_q[1:0]} : tx_s2_q;
            end
            if (launch_en)
            begin
                rx_dv_q <= tx_cap_q[4];
                rxd_q <= tx_cap_q[3:0];
            end
            // carrier on tx in half duplex, except in repeater mode
            crs_q <= rx_dv_q || (crs_on_tx && tx_s2_q[4]);
        end
    end

    assign rx_clk_out = mii_clk_q;
    assign tx_clk_out = mii_clk_q;
    assign rx_dv_out = rx_dv_q;
    assign rxd_out = rxd_q;
    assign crs_out = crs_q;
    assign power_down_out = strap_pd_q;
    assign repeater_out = repeater_q;

    // bus slave: address and data taken in either order
    assign aw_take = awvalid_in && awready_q;
    assign w_take = wvalid_in && wready_q;
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign aw_have_d = (aw_have_q || aw_take) && !do_write;
    assign w_have_d = (w_have_q || w_take) && !do_write;
    assign ar_take = arvalid_in && arready_q;
    assign addr_ok = waddr_q == `CTRL_ADDR || waddr_q == `ADV_ADDR
        || waddr_q == `STAT_ADDR || waddr_q == `LINK_ADDR;

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= !aw_have_d;
            wready_q <= !w_have_d;
            if (aw_take)
            begin
                waddr_q <= awaddr_in;
            end
            if (w_take)
            begin
                wdata_q <= wdata_in;
                wstrb_q <= wstrb_in;
            end
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= addr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (bready_in)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end
        else if (ar_take)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= `RESP_OKAY;
            unique case (araddr_in)
                `CTRL_ADDR: rdata_q <= {16'h0000, ctrl_q};
                `ADV_ADDR: rdata_q <= {16'h0000, adv_q};
                `STAT_ADDR: rdata_q <= {24'h000000, link_q == LINK_RMII,
                    crs_on_tx, repeater_q, strap_pd_q, pd_active, mode_q};
                `LINK_ADDR: rdata_q <= {31'h00000000, link_q == LINK_RMII};
                default:
                begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && rready_in)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
        else if (!rvalid_q)
        begin
            arready_q <= 1'b1;
        end
    end

    assign awready_out = awready_q;
    assign wready_out = wready_q;
    assign bvalid_out = bvalid_q;
    assign bresp_out = bresp_q;
    assign arready_out = arready_q;
    assign rvalid_out = rvalid_q;
    assign rdata_out = rdata_q;
    assign rresp_out = rresp_q;

    AST_LOAD_10HD: assert property (@(posedge clk_in) disable iff (reset_in)
        hw_rise && mode_s2_q == 3'h0 |=> ctrl_q[13] == 1'b0
        && ctrl_q[12] == 1'b0 && ctrl_q[10] == 1'b0 && ctrl_q[8] == 1'b0)
        else $error("mode 000 load wrong");
    AST_LOAD_10FD: assert property (@(posedge clk_in) disable iff (reset_in)
        hw_rise && mode_s2_q == 3'h1 |=> {ctrl_q[13], ctrl_q[12],
        ctrl_q[10], ctrl_q[8]} == 4'h1)
        else $error("mode 001 load wrong");
    AST_LOAD_100HD: assert property (@(posedge clk_in) disable iff (reset_in)
        hw_rise && mode_s2_q == 3'h2 |=> {ctrl_q[13], ctrl_q[12],
        ctrl_q[10], ctrl_q[8]} == 4'h8 && crs_on_tx)
        else $error("mode 010 load wrong");
    AST_LOAD_100FD: assert property (@(posedge clk_in) disable iff (reset_in)
        hw_rise && mode_s2_q == 3'h3 |=> {ctrl_q[13], ctrl_q[12],
        ctrl_q[10], ctrl_q[8]} == 4'h9 && !crs_on_tx)
        else $error("mode 011 load wrong");
    AST_LOAD_AN_HD: assert property (@(posedge clk_in) disable iff (reset_in)
        hw_rise && mode_s2_q == 3'h4 |=> adv_q[8:5] == 4'h4
        && {ctrl_q[13], ctrl_q[12], ctrl_q[10], ctrl_q[8]} == 4'hC)
        else $error("mode 100 load wrong");
    AST_LOAD_REP: assert property (@(posedge clk_in) disable iff (reset_in)
        hw_rise && mode_s2_q == 3'h5 |=> repeater_out && adv_q[8:5] == 4'h4
        && !crs_on_tx)
        else $error("mode 101 load wrong");
    AST_STRAP_PD: assert property (@(posedge clk_in) disable iff (reset_in)
        hw_rise && mode_s2_q == 3'h6 |=> power_down_out
        && ctrl_q == $past(ctrl_q) ##1 !rx_dv_out && !crs_out)
        else $error("mode 110 not powered down");
    AST_LOAD_ALL: assert property (@(posedge clk_in) disable iff (reset_in)
        hw_rise && mode_s2_q == 3'h7 |=> adv_q[8:5] == 4'hF
        && ctrl_q[12] && !ctrl_q[10])
        else $error("mode 111 load wrong");
    AST_SRST_KEEP: assert property (@(posedge clk_in) disable iff (reset_in)
        wr_ctrl && hw_s2_q && !hw_rise |=> mode_q == $past(mode_q)
        && !ctrl_q[15] && ctrl_q[13] == $past(wr_val[13]))
        else $error("soft reset changed config");
    // a speed write may stretch the half period in flight
    AST_MII_FAST: assert property (
        @(posedge clk_in) disable iff (reset_in || dp_clear)
        $rose(rx_clk_out) && ctrl_q[13] && link_q == LINK_MII
        |=> (rx_clk_out || !ctrl_q[13]) ##1 (!rx_clk_out || !ctrl_q[13]))
        else $error("mii clock half period not 2 cycles");
    AST_RMII_LAUNCH: assert property (@(posedge clk_in) disable iff (reset_in)
        link_q == LINK_RMII && $past(!dp_clear) && !dp_clear
        && !$stable(rxd_out) |-> $past(ref_rise))
        else $error("rmii rx moved off reference edge");
endmodule : strap_mode_config

// >>> src/strap_mode_config_defs.svh
`ifndef STRAP_MODE_CONFIG_DEFS_SVH
`define STRAP_MODE_CONFIG_DEFS_SVH

`define CTRL_ADDR 8'h00
`define ADV_ADDR 8'h04
`define STAT_ADDR 8'h08
`define LINK_ADDR 8'h0C

`define CTRL_RESET 16'h3100
`define ADV_RESET 16'h01E1
`define LINK_RESET 1'h0

`define CTRL_SRST_BIT 15
`define CTRL_SPEED_BIT 13
`define CTRL_ANEG_BIT 12
`define CTRL_PDOWN_BIT 11
`define CTRL_ISO_BIT 10
`define CTRL_DUPLEX_BIT 8
`define ADV_ABIL_MSB 8
`define ADV_ABIL_LSB 5

`define MODE_10HD 3'h0
`define MODE_10FD 3'h1
`define MODE_100HD 3'h2
`define MODE_100FD 3'h3
`define MODE_100HD_AN 3'h4
`define MODE_REPEATER 3'h5
`define MODE_PDOWN 3'h6
`define MODE_ALL 3'h7

`define CTRL4_10HD 4'h0
`define CTRL4_10FD 4'h1
`define CTRL4_100HD 4'h8
`define CTRL4_100FD 4'h9
`define CTRL4_AN_100HD 4'hC
`define ADV4_100HD 4'h4
`define ADV4_ALL 4'hF

`define SYS_CLK_NS 10
`define MII_PERIOD_100_NS 40
`define MII_PERIOD_10_NS 400
`define MII_HALF_100_CYC 5'((`MII_PERIOD_100_NS / 2) / `SYS_CLK_NS)
`define MII_HALF_10_CYC 5'((`MII_PERIOD_10_NS / 2) / `SYS_CLK_NS)

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> src/strap_mode_config_pkg.sv
package strap_mode_config_pkg;
    typedef logic [2:0] strap_type;
    typedef logic [15:0] reg16_type;
    typedef logic [7:0] addr_type;
    typedef enum logic {LINK_MII, LINK_RMII} link_type;
endpackage : strap_mode_config_pkg

// >>> test/mac_model.sv
`timescale 1ns/10ps
module mac_model (
    input wire logic tx_clk_in,
    input wire logic ref_clock_in,
    input wire logic rmii_in,
    input wire logic req_en_in,
    input wire logic [3:0] req_data_in,
    output logic tx_en_out,
    output logic [3:0] txd_out
);
    logic launch_clk;
    assign launch_clk = rmii_in ? ref_clock_in : tx_clk_in;
    initial
    begin
        tx_en_out = 1'b0;
        txd_out = 4'h0;
    end
    always @(posedge launch_clk)
    begin
        tx_en_out <= req_en_in;
        // idle lines toggle, never hold stale data
        txd_out <= req_en_in ? req_data_in : ~txd_out;
    end
endmodule : mac_model

// >>> test/strap_mode_config_tb_top.sv
`timescale 1ns/10ps
`include "strap_mode_config_defs.svh"
module strap_mode_config_tb_top;
    import strap_mode_config_pkg::*;
    typedef struct packed {logic [31:0] data; logic [31:0] mask;
        logic [1:0] resp;} note_type;
    localparam logic [3:0] ctrl4_tab [8] = '{4'h0, 4'h1, 4'h8, 4'h9,
        4'hC, 4'hC, 4'hD, 4'hD};
    localparam logic [3:0] adv4_tab [8] = '{4'hF, 4'hF, 4'hF, 4'hF,
        4'h4, 4'h4, 4'hF, 4'hF};
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic pin_n = 1'b0;
    strap_type strap = 3'h0;
    logic ref_clock = 1'b0;
    logic rmii = 1'b0, req_en = 1'b0, tx_en;
    logic [3:0] req_data = 4'h0, txd, rxd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    addr_type awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic rx_clk, tx_clk, rx_dv, crs, power_down, repeater;
    int error_cnt = 0;
    int tests_run = 0;
    note_type notes [$];

    strap_mode_config strap_mode_config_inst (.clk_in(clk_in),
        .reset_in(reset_in), .hw_reset_pin_n_in(pin_n),
        .mode_strap_in(strap), .ref_clock_input_in(ref_clock),
        .tx_en_in(tx_en), .txd_in(txd), .rx_clk_out(rx_clk),
        .tx_clk_out(tx_clk), .rx_dv_out(rx_dv), .rxd_out(rxd),
        .crs_out(crs), .power_down_out(power_down),
        .repeater_out(repeater), .awvalid_in(awvalid),
        .awready_out(awready), .awaddr_in(awaddr), .wvalid_in(wvalid),
        .wready_out(wready), .wdata_in(wdata), .wstrb_in(wstrb),
        .bvalid_out(bvalid), .bready_in(bready), .bresp_out(bresp),
        .arvalid_in(arvalid), .arready_out(arready), .araddr_in(araddr),
        .rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata),
        .rresp_out(rresp));
    mac_model mac_model_inst (.tx_clk_in(tx_clk), .ref_clock_in(ref_clock),
        .rmii_in(rmii), .req_en_in(req_en), .req_data_in(req_data),
        .tx_en_out(tx_en), .txd_out(txd));

    always #5 clk_in = ~clk_in;
    // link clock free running, phase unrelated to clk_in
    initial
    begin
        #3;
        forever #80 ref_clock = ~ref_clock;
    end

    task final_report;
        if (error_cnt == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task check(input string what, input logic [31:0] exp,
        input logic [31:0] seen);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task give_up(input string what);
        error_cnt++;
        $display("mismatch %s expected answer seen none", what);
        final_report();
    endtask : give_up

    task axi_write(input addr_type a, input logic [31:0] d,
        input logic [1:0] er);
        int n;
        logic aw_ok;
        logic w_ok;
        notes.push_back('{32'h0, 32'h0, er});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        for (n = 0; !(aw_ok && w_ok); n++)
        begin
            @(posedge clk_in);
            if (!aw_ok && awready === 1'b1)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
            if (n > 100)
                give_up("write");
        end
        for (n = 0; bvalid !== 1'b1 || n == 0; n++)
        begin
            @(posedge clk_in);
            if (n > 100)
                give_up("bvalid");
        end
        bready <= 1'b0;
        @(posedge clk_in);
    endtask : axi_write

    task axi_read(input addr_type a, input logic [31:0] exp,
        input logic [31:0] mask, input logic [1:0] er);
        int n;
        notes.push_back('{exp, mask, er});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; arready !== 1'b1 || n == 0; n++)
        begin
            @(posedge clk_in);
            if (n > 100)
                give_up("arready");
        end
        arvalid <= 1'b0;
        for (n = 0; rvalid !== 1'b1 || n == 0; n++)
        begin
            @(posedge clk_in);
            if (n > 100)
                give_up("rvalid");
        end
        rready <= 1'b0;
        @(posedge clk_in);
    endtask : axi_read

    // responses appear here and are matched to the oldest note
    always @(posedge clk_in)
    begin : watch
        note_type e;
        if (bvalid === 1'b1 && bready === 1'b1 && notes.size() > 0)
        begin
            e = notes.pop_front();
            check("bresp", 32'(e.resp), 32'(bresp));
        end
        if (rvalid === 1'b1 && rready === 1'b1 && notes.size() > 0)
        begin
            e = notes.pop_front();
            check("rresp", 32'(e.resp), 32'(rresp));
            check("rdata", e.data, rdata & e.mask);
        end
    end

    task hw_boot(input strap_type m);
        pin_n <= 1'b0;
        strap <= m;
        repeat (5) @(posedge clk_in);
        pin_n <= 1'b1;
        repeat (10) @(posedge clk_in);
    endtask : hw_boot

    task clk_period(input int exp);
        int n;
        int first;
        int second;
        logic prev;
        prev = tx_clk;
        first = -1;
        second = -1;
        for (n = 0; n < 200 && second < 0; n++)
        begin
            @(posedge clk_in);
            if (prev === 1'b0 && tx_clk === 1'b1)
            begin
                if (first < 0)
                    first = n;
                else
                    second = n;
            end
            prev = tx_clk;
        end
        check("mii_period", 32'(exp), 32'(second - first));
        check("rx_clk", 32'(tx_clk), 32'(rx_clk));
    endtask : clk_period

    initial
    begin
        logic [15:0] ctl;
        logic [15:0] adv;
        logic [7:0] st;
        logic [31:0] d;
        void'($urandom(32'h2136));
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        for (int m = 0; m < 8; m++)
        begin
            hw_boot(3'(m));
            ctl = `CTRL_RESET;
            {ctl[13], ctl[12], ctl[10], ctl[8]} = ctrl4_tab[m];
            adv = `ADV_RESET;
            adv[8:5] = adv4_tab[m];
            st = {1'b0, ~ctl[8] & (m != 5), m == 5, m == 6, 1'b0, 3'(m)};
            axi_read(`CTRL_ADDR, 32'(ctl), 32'hFFFF, `RESP_OKAY);
            axi_read(`ADV_ADDR, 32'(adv), 32'hFFFF, `RESP_OKAY);
            axi_read(`STAT_ADDR, 32'(st), 32'h77, `RESP_OKAY);
            check("power_down", 32'(m == 6), 32'(power_down));
            check("repeater", 32'(m == 5), 32'(repeater));
        end
        axi_write(8'h10, 32'hFFFF, `RESP_SLVERR);
        axi_read(8'h10, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
        axi_read(`CTRL_ADDR, 32'h3100, 32'hFFFF, `RESP_OKAY);
        hw_boot(3'h6);
        d = 32'hA000 | (32'($urandom_range(0, 1)) << 8);
        axi_write(`CTRL_ADDR, d, `RESP_OKAY);
        check("power_down", 32'h1, 32'(power_down));
        // straps moved away, then soft reset
        strap <= 3'h0;
        repeat (5) @(posedge clk_in);
        axi_write(`CTRL_ADDR, d, `RESP_OKAY);
        repeat (3) @(posedge clk_in);
        check("power_down", 32'h0, 32'(power_down));
        axi_read(`CTRL_ADDR, d & 32'h7FFF, 32'hFFFF, `RESP_OKAY);
        clk_period(4);
        req_data <= 4'($urandom());
        req_en <= 1'b1;
        repeat (40) @(posedge clk_in);
        check("rx_dv", 32'h1, 32'(rx_dv));
        check("rxd", 32'(req_data), 32'(rxd));
        check("crs", 32'h1, 32'(crs));
        axi_write(`CTRL_ADDR, 32'h0100, `RESP_OKAY);
        clk_period(40);
        axi_write(`LINK_ADDR, 32'h1, `RESP_OKAY);
        rmii <= 1'b1;
        req_data <= 4'($urandom());
        repeat (100) @(posedge clk_in);
        check("tx_clk", 32'h0, 32'(tx_clk));
        check("rxd", 32'(req_data[1:0]), 32'(rxd[1:0]));
        req_en <= 1'b0;
        repeat (100) @(posedge clk_in);
        check("rx_dv", 32'h0, 32'(rx_dv));
        final_report();
    end
endmodule : strap_mode_config_tb_top
